// >>> include/cfg_seq_regs.vh
// constants for the configuration sequencer and error-check timing block
`ifndef CFG_SEQ_REGS_VH
`define CFG_SEQ_REGS_VH
// ----------------------------------------
// divisor range for error-detection clock
// ----------------------------------------
`define EDC_DIV_MIN        4'h2
`define EDC_DIV_MAX        4'h8
`define EDC_DIV_RST        4'h2
// ----------------------------------------
// sequencing delays and counts; POR and init counts in CLK cycles
// ----------------------------------------
`define POR_DELAY_NS       1000
`define CLK_PERIOD_NS      50
`define POR_CYCLES         ((`POR_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_CYCLES        16'h0040
`define FRAME_WORDS        16'h0100
`define CRC_WORD_CYCLES    16'h0002
`define SIG_WIDTH          32
`define CRC_POLY           32'h04C1_1DB7
`endif

// >>> core/cfg_sequencer.v
// configuration sequencer with user-mode error-detection crc timing
// Contract
// - check clock is oscillator over two to n
// - divided check clock kept inside limits; here the slowest divisors give a check clock below the lower limit
// - pass time scales by n over two; here a pass is 512 ticks of 2**n cycles, doubling per step of n
// - divisor-two pass within size-dependent window
// - compressed stream decompressed on the fly
// - reload low drives status, done low; io parked
// - power-up enters configuration after short delay
// - configuration copies flash into configuration memory
// - auto restart after configuration error when enabled
// - initialization starts after done, oscillator clocked
// - after initialization enter user mode
// - dual-purpose pins config before user mode
// - crc open-drain; status, done bidirectional
// - differential test pins lose test function
// - crc error follows latest pass signature
// - check clocked via divisor, starts in user
`timescale 1ns/1ps
`include "cfg_seq_regs.vh"

module cfg_sequencer (
   // clock and reset
   input  wire        CLK,
   input  wire        SYS_RST,
   // configuration pins (open-drain: oe low while driving)
   input  wire        RELOAD_REQUEST_N,
   input  wire        CONFIG_STATE_N_IN,
   output reg         CONFIG_STATE_N_OUT,
   output reg         CONFIG_STATE_N_OE_N,
   input  wire        LOAD_COMPLETE_IN,
   output reg         LOAD_COMPLETE_OUT,
   output reg         LOAD_COMPLETE_OE_N,
   output reg         CRC_ERROR_OUT,
   output reg         CRC_ERROR_OE_N,
   // stored option bits
   input  wire        AUTO_RESTART_EN,
   input  wire        IO_WEAK_PULLUP,
   input  wire        CRC_CHECK_EN,
   input  wire [3:0]  CRC_DIVISOR,
   input  wire        COMPRESSED_IMAGE,
   input  wire        PINS_AS_USER_IO,
   input  wire        TEST_PIN_SHARING,
   input  wire        TEST_PORT_ENABLE,
   input  wire        TEST_PIN_DIFFERENTIAL,
   // configuration flash read port
   output reg  [15:0] FLASH_ADDR,
   input  wire [31:0] FLASH_DATA,
   input  wire        FLASH_ERROR,
   // configuration memory write and read-back port
   output reg  [15:0] CMEM_ADDR,
   output reg  [31:0] CMEM_WDATA,
   output reg         CMEM_WE,
   input  wire [31:0] CMEM_RDATA,
   // stored crc reference and user-side status
   input  wire [31:0] CRC_REFERENCE,
   output reg         USER_MODE,
   output reg         USER_IO_PULLUP,
   output reg         USER_IO_HIZ,
   output reg         CONFIG_PINS_ACTIVE,
   output reg         TEST_PORT_ACTIVE,
   output reg         CRC_PASS_DONE
);

   // ----------------------------------------
   // states, one-hot
   // ----------------------------------------
   localparam [5:0] S_POR   = 6'h01;
   localparam [5:0] S_CFG   = 6'h02;
   localparam [5:0] S_INIT  = 6'h04;
   localparam [5:0] S_USER  = 6'h08;
   localparam [5:0] S_HOLD  = 6'h10;   // reload low
   localparam [5:0] S_ERR   = 6'h20;   // config error, waits for reload
   localparam integer POR_INT = `POR_CYCLES;       // power-on delay in clk cycles
   localparam [15:0] POR_CNT = POR_INT[15:0];

   reg  [5:0]  state_q;         // sequencer state
   reg  [15:0] cnt_q;           // por / init / word counter
   reg  [15:0] rd_q;            // flash read pointer
   reg         rle_q;           // decompressor: repeat in progress
   reg  [15:0] rle_left_q;      // remaining repeats of a run
   reg  [31:0] rle_word_q;      // word being repeated
   reg  [8:0]  div_q;           // crc clock prescaler
   reg  [3:0]  n_q;             // divisor latched at user entry
   reg  [31:0] sig_q;           // running crc over memory
   reg  [15:0] crc_addr_q;      // crc read pointer
   reg         tick_d;          // one error-detection clock

   // limitation: clk stands in for the oscillator here, so the slowest
   // divisors give a check clock below the lower limit; a faster
   // oscillator clock keeps every n inside the limits
   // clamp divisor to legal range 2 to 8, keeps n inside its limits
   wire [3:0] n_use = (CRC_DIVISOR < `EDC_DIV_MIN) ? `EDC_DIV_MIN :
                      (CRC_DIVISOR > `EDC_DIV_MAX) ? `EDC_DIV_MAX :
                      CRC_DIVISOR;
   wire [8:0] div_top = (9'h001 << n_q) - 9'h001;

   // ----------------------------------------
   // crc step over one memory word
   // ----------------------------------------
   // one word folded per call; the bit loop unrolls into an xor tree
   function [31:0] crc_step;
      input [31:0] c;
      input [31:0] d;
      integer i;
      reg [31:0] r;
      begin
         r = c ^ d;
         for (i = 0; i < 32; i = i + 1) begin
            r = r[31] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
         end
         crc_step = r;
      end
   endfunction

   // error-detection clock: 2**n cycles of oscillator per tick
   always @* begin
      tick_d = (state_q == S_USER) && CRC_CHECK_EN && (div_q == div_top);
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always @(posedge CLK) begin
      if (SYS_RST) begin
         state_q      <= S_POR;
         cnt_q        <= 16'h0000;
         rd_q         <= 16'h0000;
         rle_q        <= 1'b0;
         rle_left_q   <= 16'h0000;
         rle_word_q   <= 32'h0000_0000;
         div_q        <= 9'h000;
         n_q          <= `EDC_DIV_RST;
         sig_q        <= 32'h0000_0000;
         crc_addr_q   <= 16'h0000;
         FLASH_ADDR   <= 16'h0000;
         CMEM_ADDR    <= 16'h0000;
         CMEM_WDATA   <= 32'h0000_0000;
         CMEM_WE      <= 1'b0;
         CRC_ERROR_OUT  <= 1'b0;
         CRC_PASS_DONE  <= 1'b0;
      end else begin
         CMEM_WE       <= 1'b0;
         CRC_PASS_DONE <= 1'b0;
         if (!RELOAD_REQUEST_N) begin
            // reload low: configuration restarts on release
            state_q <= S_HOLD;
            cnt_q   <= 16'h0000;
            CRC_ERROR_OUT <= 1'b0;
         end else begin
            case (state_q)
               S_POR: begin
                  // short power-on delay before configuration
                  cnt_q <= cnt_q + 16'h0001;
                  if (cnt_q >= POR_CNT) begin
                     state_q <= S_CFG;
                     // rewind the flash pointer for a clean first word
                     FLASH_ADDR <= 16'h0000;
                     cnt_q   <= 16'h0000;
                     rd_q    <= 16'h0000;
                     rle_q   <= 1'b0;
                  end
               end
               S_HOLD: begin
                  // release repeats the sequence from configuration on, without the power-on delay
                  state_q <= S_CFG;
                  // else the first word would come from the old image end
                  FLASH_ADDR <= 16'h0000;
                  cnt_q   <= 16'h0000;
                  rd_q    <= 16'h0000;
                  rle_q   <= 1'b0;
               end
               S_CFG: begin
                  if (FLASH_ERROR) begin
                     state_q <= AUTO_RESTART_EN ? S_HOLD : S_ERR;
                  end else if (cnt_q == `FRAME_WORDS) begin
                     state_q <= S_INIT;
                     cnt_q   <= 16'h0000;
                  end else if (rle_q) begin
                     // expand a run, no separate decompress pass
                     CMEM_WE    <= 1'b1;
                     CMEM_ADDR  <= cnt_q;
                     CMEM_WDATA <= rle_word_q;
                     cnt_q      <= cnt_q + 16'h0001;
                     rle_left_q <= rle_left_q - 16'h0001;
                     if (rle_left_q == 16'h0001) begin
                        rle_q <= 1'b0;
                     end
                  end else if (COMPRESSED_IMAGE && FLASH_DATA[31:16] == 16'hFFFF) begin
                     // run header: low half counts zero words to write
                     rle_q      <= (FLASH_DATA[15:0] != 16'h0000);
                     rle_left_q <= FLASH_DATA[15:0];
                     rle_word_q <= 32'h0000_0000;
                     rd_q       <= rd_q + 16'h0001;
                     FLASH_ADDR <= rd_q + 16'h0001;
                  end else begin
                     // plain copy flash to memory
                     CMEM_WE    <= 1'b1;
                     CMEM_ADDR  <= cnt_q;
                     CMEM_WDATA <= FLASH_DATA;
                     cnt_q      <= cnt_q + 16'h0001;
                     rd_q       <= rd_q + 16'h0001;
                     FLASH_ADDR <= rd_q + 16'h0001;
                  end
               end
               S_INIT: begin
                  // done is released; wait for pin high, then clock init
                  if (LOAD_COMPLETE_IN) begin
                     cnt_q <= cnt_q + 16'h0001;
                  end
                  if (cnt_q == `INIT_CYCLES) begin
                     state_q    <= S_USER;
                     n_q        <= n_use;
                     div_q      <= 9'h000;
                     sig_q      <= 32'hFFFF_FFFF;
                     crc_addr_q <= 16'h0000;
                     // check starts at word zero, not the last loaded word
                     CMEM_ADDR  <= 16'h0000;
                     cnt_q      <= 16'h0000;
                  end
               end
               S_USER: begin
                  div_q <= tick_d ? 9'h000 : div_q + 9'h001;
                  if (tick_d) begin
                     // one word per two ticks: pass time grows with n
                     cnt_q <= cnt_q + 16'h0001;
                     if (cnt_q == `CRC_WORD_CYCLES - 16'h0001) begin
                        cnt_q      <= 16'h0000;
                        CMEM_ADDR  <= crc_addr_q + 16'h0001;
                        crc_addr_q <= crc_addr_q + 16'h0001;
                        if (crc_addr_q == `FRAME_WORDS - 16'h0001) begin
                           // pass done: error tracks this pass only
                           CRC_ERROR_OUT <= ((crc_step(sig_q, CMEM_RDATA)
                                             ^ CRC_REFERENCE) != 32'h0000_0000);
                           CRC_PASS_DONE <= 1'b1;
                           sig_q         <= 32'hFFFF_FFFF;
                           crc_addr_q    <= 16'h0000;
                           CMEM_ADDR     <= 16'h0000;
                        end else begin
                           sig_q <= crc_step(sig_q, CMEM_RDATA);
                        end
                     end
                  end
               end
               S_ERR: begin
                  // waits for the controller to pulse reload
                  state_q <= S_ERR;
               end
               default: state_q <= S_POR;
            endcase
         end
      end
   end

   // ----------------------------------------
   // pins and user-side status
   // ----------------------------------------
   always @(posedge CLK) begin
      if (SYS_RST) begin
         CONFIG_STATE_N_OUT  <= 1'b0;
         CONFIG_STATE_N_OE_N <= 1'b0;
         LOAD_COMPLETE_OUT   <= 1'b0;
         LOAD_COMPLETE_OE_N  <= 1'b0;
         CRC_ERROR_OE_N      <= 1'b0;   // no error in reset: pin held low
         USER_MODE           <= 1'b0;
         USER_IO_PULLUP      <= 1'b0;
         USER_IO_HIZ         <= 1'b1;
         CONFIG_PINS_ACTIVE  <= 1'b1;
         TEST_PORT_ACTIVE    <= 1'b1;
      end else begin
         CONFIG_STATE_N_OUT <= 1'b0;
         LOAD_COMPLETE_OUT  <= 1'b0;
         // status pulled low in hold, por and error; done low until config ends
         CONFIG_STATE_N_OE_N <= !(state_q == S_HOLD || state_q == S_POR ||
                                  state_q == S_ERR || !RELOAD_REQUEST_N);
         LOAD_COMPLETE_OE_N  <= !(state_q == S_HOLD || state_q == S_POR ||
                                  state_q == S_CFG || state_q == S_ERR ||
                                  !RELOAD_REQUEST_N);
         // open-drain: only pull low when error is absent
         CRC_ERROR_OE_N <= CRC_ERROR_OUT;
         USER_MODE      <= (state_q == S_USER) && RELOAD_REQUEST_N;
         // reload low parks io at once, in the same cycle the state enters hold
         USER_IO_PULLUP <= ((state_q != S_USER) || !RELOAD_REQUEST_N) && IO_WEAK_PULLUP;
         USER_IO_HIZ    <= ((state_q != S_USER) || !RELOAD_REQUEST_N) && !IO_WEAK_PULLUP;
         CONFIG_PINS_ACTIVE <= (state_q != S_USER) || !PINS_AS_USER_IO;
         // shared test pins follow enable; differential pins lose it
         TEST_PORT_ACTIVE <= (state_q != S_USER) ||
                             (!TEST_PIN_DIFFERENTIAL &&
                              (!TEST_PIN_SHARING || TEST_PORT_ENABLE));
      end
   end

endmodule // cfg_sequencer

// >>> verification/cfg_sequencer_asserts.sv
// port assertions for the configuration sequencer
`timescale 1ns/1ps
module cfg_seq_chk (
   // watched ports
   input wire       CLK,
   input wire       SYS_RST,
   input wire       RELOAD_REQUEST_N,
   input wire       LOAD_COMPLETE_IN,
   input wire       CONFIG_STATE_N_OE_N,
   input wire       LOAD_COMPLETE_OE_N,
   input wire       CRC_ERROR_OUT,
   input wire       CRC_ERROR_OE_N,
   input wire [3:0] CRC_DIVISOR,
   input wire       TEST_PIN_DIFFERENTIAL,
   input wire       USER_MODE,
   input wire       USER_IO_PULLUP,
   input wire       USER_IO_HIZ,
   input wire       TEST_PORT_ACTIVE,
   input wire       CRC_PASS_DONE
);
   // ----------------------------------------
   // helper counters
   // ----------------------------------------
   reg  [7:0]  done_q; // done-high run, saturates
   reg  [17:0] gap_q;  // cycles since last pass
   reg         seen_q; // a pass seen this session
   wire [3:0]  n = (CRC_DIVISOR < 2) ? 4'h2 : (CRC_DIVISOR > 8) ? 4'h8 : CRC_DIVISOR;
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   // gap restarts at each pass and outside user mode
   always @(posedge CLK) begin
      done_q <= (SYS_RST || !LOAD_COMPLETE_IN) ? 8'h00 : done_q + {7'h0, done_q != 8'hFF};
      gap_q  <= (CRC_PASS_DONE || !USER_MODE) ? 18'h1 : gap_q + 18'h1;
      seen_q <= !SYS_RST && USER_MODE && (seen_q || CRC_PASS_DONE);
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   AST_RELOAD_LOW:
      assert property (!RELOAD_REQUEST_N |=> !CONFIG_STATE_N_OE_N && !LOAD_COMPLETE_OE_N)
      else $error("status or done not pulled low");
   AST_IO_PARKED:
      assert property (!RELOAD_REQUEST_N && $past(!RELOAD_REQUEST_N)
         |-> !USER_MODE && (USER_IO_HIZ != USER_IO_PULLUP))
      else $error("user io not parked during reload");
   AST_CRC_PIN:
      assert property (CRC_ERROR_OE_N == $past(CRC_ERROR_OUT))
      else $error("crc pin drive disagrees with level");
   AST_INIT_AFTER_DONE:
      assert property ($rose(USER_MODE) |-> done_q >= 8'd63)
      else $error("user mode without full init after done");
   AST_CRC_IDLE:
      assert property (CRC_PASS_DONE |-> USER_MODE)
      else $error("crc pass outside user mode");
   AST_CRC_FOLLOWS_PASS:
      assert property ($changed(CRC_ERROR_OUT)
         |-> CRC_PASS_DONE || $past(CRC_PASS_DONE) || !USER_MODE)
      else $error("crc error moved between passes");
   AST_PASS_PERIOD:
      assert property (CRC_PASS_DONE && seen_q |-> gap_q == (18'h200 << n))
      else $error("crc pass period wrong");
   AST_POR_DELAY:
      assert property ($fell(SYS_RST) |-> !USER_MODE [*8])
      else $error("user mode right after reset");
   AST_TEST_DIFF:
      assert property (USER_MODE && $past(USER_MODE) && TEST_PIN_DIFFERENTIAL
         && $past(TEST_PIN_DIFFERENTIAL) |-> !TEST_PORT_ACTIVE)
      else $error("test port active on differential pins");
endmodule // cfg_seq_chk

bind cfg_sequencer cfg_seq_chk i_cfg_seq_chk (.CLK(CLK), .SYS_RST(SYS_RST),
   .RELOAD_REQUEST_N(RELOAD_REQUEST_N), .LOAD_COMPLETE_IN(LOAD_COMPLETE_IN),
   .CONFIG_STATE_N_OE_N(CONFIG_STATE_N_OE_N), .LOAD_COMPLETE_OE_N(LOAD_COMPLETE_OE_N),
   .CRC_ERROR_OUT(CRC_ERROR_OUT), .CRC_ERROR_OE_N(CRC_ERROR_OE_N),
   .CRC_DIVISOR(CRC_DIVISOR), .TEST_PIN_DIFFERENTIAL(TEST_PIN_DIFFERENTIAL),
   .USER_MODE(USER_MODE), .USER_IO_PULLUP(USER_IO_PULLUP), .USER_IO_HIZ(USER_IO_HIZ),
   .TEST_PORT_ACTIVE(TEST_PORT_ACTIVE), .CRC_PASS_DONE(CRC_PASS_DONE));

// >>> verification/cfg_far_side.sv
// far-side model: controller, flash, configuration memory, pull-ups
`timescale 1ns/1ps
module cfg_far_side #(
   parameter MIN_LOW = 4 // reload_min_low_pulse in cycles
) (
   input  wire        clk,
   input  wire        hold_low,
   output wire        reload_n,
   input  wire        st_oe_n,
   input  wire        dn_oe_n,
   output wire        st_in,
   output wire        dn_in,
   input  wire [15:0] flash_addr,
   output wire [31:0] flash_data,
   input  wire [15:0] cmem_addr,
   input  wire [31:0] cmem_wdata,
   input  wire        cmem_we,
   output wire [31:0] cmem_rdata
);
   reg [31:0] flash [0:511]; // stored image
   reg [31:0] cmem [0:255];  // configuration memory
   reg [3:0]  low_q = 4'h0;  // reload low cycles left
   // short requests are stretched, never narrower than the minimum
   always @(posedge clk) begin
      if (hold_low)
         low_q <= MIN_LOW;
      else if (low_q != 0)
         low_q <= low_q - 4'h1;
      if (cmem_we)
         cmem[cmem_addr[7:0]] <= cmem_wdata;
   end
   assign reload_n   = (low_q == 0);
   // controller tri-stated, pull-ups fitted
   assign st_in      = st_oe_n ? 1'b1 : 1'b0;
   assign dn_in      = dn_oe_n ? 1'b1 : 1'b0;
   assign flash_data = flash[flash_addr[8:0]];
   assign cmem_rdata = cmem[cmem_addr[7:0]];
endmodule // cfg_far_side

// >>> verification/tb_cfg_sequencer.sv
// self-checking bench for the configuration sequencer
`timescale 1ns/1ps
`include "cfg_seq_regs.vh"
module tb_cfg_sequencer;
   reg clk = 0, sys_rst = 1, hold = 0, auto = 0, wpu = 0, comp = 0, diff = 1, ferr = 0;
   reg cen = 1, pau = 0, tps = 0, tpe = 1;
   reg [3:0] div = 4'h2;
   reg [31:0] crc_ref = 0, lf = 32'hf66a_99cd;
   reg q[$];
   reg eb;
   integer n_fail = 0, n_checks = 0, i, n_pass = 0, k0;
   wire rn, si, so, se, di, d_o, de, crc, um, pu, hz, tpa, pd, we, ce_n, cpa;
   wire [15:0] fa, ca;
   wire [31:0] fd, cw, cr;
   always #25 clk = ~clk;
   cfg_sequencer i_cfg_sequencer (.CLK(clk), .SYS_RST(sys_rst), .RELOAD_REQUEST_N(rn),
      .CONFIG_STATE_N_IN(si), .CONFIG_STATE_N_OUT(so), .CONFIG_STATE_N_OE_N(se),
      .LOAD_COMPLETE_IN(di), .LOAD_COMPLETE_OUT(d_o), .LOAD_COMPLETE_OE_N(de),
      .CRC_ERROR_OUT(crc), .CRC_ERROR_OE_N(ce_n), .AUTO_RESTART_EN(auto),
      .IO_WEAK_PULLUP(wpu), .CRC_CHECK_EN(cen), .CRC_DIVISOR(div),
      .COMPRESSED_IMAGE(comp), .PINS_AS_USER_IO(pau), .TEST_PIN_SHARING(tps),
      .TEST_PORT_ENABLE(tpe), .TEST_PIN_DIFFERENTIAL(diff), .FLASH_ADDR(fa),
      .FLASH_DATA(fd), .FLASH_ERROR(ferr), .CMEM_ADDR(ca), .CMEM_WDATA(cw),
      .CMEM_WE(we), .CMEM_RDATA(cr), .CRC_REFERENCE(crc_ref), .USER_MODE(um),
      .USER_IO_PULLUP(pu), .USER_IO_HIZ(hz), .CONFIG_PINS_ACTIVE(cpa),
      .TEST_PORT_ACTIVE(tpa), .CRC_PASS_DONE(pd));
   cfg_far_side i_cfg_far_side (.clk(clk), .hold_low(hold), .reload_n(rn), .st_oe_n(se),
      .dn_oe_n(de), .st_in(si), .dn_in(di), .flash_addr(fa), .flash_data(fd),
      .cmem_addr(ca), .cmem_wdata(cw), .cmem_we(we), .cmem_rdata(cr));
   function [31:0] nxt(input [31:0] v);
      nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // expected check value: init all ones, fold words in address order
   function [31:0] crc_w(input [31:0] c, input [31:0] d);
      integer j;
      reg [31:0] r;
      begin
         r = c ^ d;
         for (j = 0; j < 32; j = j + 1)
            r = r[31] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
         crc_w = r;
      end
   endfunction
   task tick;
      begin @(posedge clk); #1; end
   endtask
   task chk(input [31:0] g, input [31:0] e, input string m);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
         end
      end
   endtask
   task results;
      begin
         $display("checks %0d mismatches %0d", n_checks, n_fail);
         if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   // bounded wait for user mode
   task wait_user;
      integer k;
      begin
         k = 0;
         while (um !== 1'b1 && k < 8000) begin tick; k = k + 1; end
         chk(um, 1, "user mode");
      end
   endtask
   // reload pulse; pins and io checked while it is low
   task reload;
      begin
         hold = 1;
         repeat (4) tick;
         chk({si, di, um, pu, hz, cpa, tpa}, {3'b000, wpu, !wpu, 2'b11}, "reload low");
         hold = 0;
      end
   endtask
   // drain expected crc outcomes under a bound
   task wait_q;
      integer k;
      begin
         k = 0;
         while (q.size() > 0 && k < 20000) begin tick; k = k + 1; end
         chk(q.size(), 0, "crc passes");
      end
   endtask
   // ----------------------------------------
   // result monitor: oldest note per pass
   // ----------------------------------------
   // sampled mid-cycle, where pass pulse and error level have settled
   always @(negedge clk) if (pd === 1'b1) begin
      n_pass = n_pass + 1;
      if (q.size() > 0) begin
         eb = q.pop_front();
         chk(crc, eb, "crc error level");
      end
   end
   initial begin
      for (i = 0; i < 512; i = i + 1) begin
         lf = nxt(lf);
         i_cfg_far_side.flash[i] = lf & 32'h7FFF_FFFF;
      end
      crc_ref = 32'hFFFF_FFFF;
      for (i = 0; i < 256; i = i + 1) crc_ref = crc_w(crc_ref, i_cfg_far_side.flash[i]);
      repeat (20) tick;
      sys_rst = 0;
      wait_user;
      for (i = 0; i < 256; i = i + 1) chk(i_cfg_far_side.cmem[i], i_cfg_far_side.flash[i], "word");
      chk({tpa, cpa}, 2'b01, "pins on differential");
      q.push_back(0);
      wait_q;
      chk(ce_n, 0, "crc pin pulled low");
      // upset one random word right after a pass, then repair it
      k0 = lf[7:0];
      i_cfg_far_side.cmem[k0] = i_cfg_far_side.cmem[k0] ^ 32'h0000_0001;
      q.push_back(1);
      wait_q;
      chk(ce_n, 1, "crc pin released");
      i_cfg_far_side.cmem[k0] = i_cfg_far_side.flash[k0];
      q.push_back(0);
      wait_q;
      $display("test plain load done");
      i_cfg_far_side.flash[0] = 32'hFFFF_0004;
      comp = 1;
      div = 4'h3;
      wpu = lf[0];
      reload;
      wait_user;
      for (i = 0; i < 256; i = i + 1) chk(i_cfg_far_side.cmem[i], i < 4 ? 32'h0 : i_cfg_far_side.flash[i - 3], "run");
      crc_ref = 32'hFFFF_FFFF;
      for (i = 0; i < 256; i = i + 1)
         crc_ref = crc_w(crc_ref, i < 4 ? 32'h0 : i_cfg_far_side.flash[i - 3]);
      q.push_back(0);
      wait_q;
      $display("test compressed reload done");
      // options move only between runs, never during initialization
      cen = 0;
      pau = 1;
      tps = 1;
      tpe = 0;
      diff = 0;
      ferr = 1;
      reload;
      repeat (20) tick;
      ferr = 0;
      repeat (2000) tick;
      chk({si, um}, 2'b00, "held in error");
      reload;
      wait_user;
      chk({tpa, cpa}, 2'b00, "shared pins handed to user");
      k0 = n_pass;
      repeat (4200) tick;
      chk(n_pass, k0, "no pass with check off");
      chk(crc, 0, "crc error idle");
      $display("test error no restart done");
      auto = 1;
      cen = 1;
      tpe = 1;
      ferr = 1;
      reload;
      repeat (20) tick;
      ferr = 0;
      wait_user;
      chk({tpa, cpa}, 2'b10, "test port kept by enable");
      $display("test auto restart done");
      results;
   end
   initial begin
      repeat (60000) @(posedge clk);
      n_fail = n_fail + 1;
      $display("CHECK FAILED t=%0t watchdog", $time);
      results;
   end
endmodule // tb_cfg_sequencer
